/* bus_pin_config.sv */
// Reset straps, line write-back marking and output pin states in hold and stop.
`timescale 1ns/10ps
`include "pin_state_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Pin vector order, bit 0 upward: byte_enables[3:0], page_writethrough_attr,
// page_uncached_attr, cycle definition [2:0], bus lock, multi_cycle_atomic_out,
// address_strobe, last_transfer, low_address_bits[1:0] (bits 13,14 are the
// address bits). Line-allocatable and modified_snoop_hit sit in a separate pair.
////////////////////////////////////////////////////////////////////////////////

// Contract
// - Strap active at reset enables write-back mode
// - Each filled line marked write-back or write-through
// - Strap sampled with first ready of fill
// - Ratio strap latched at reset, held
// - Low means double, high means triple
// - Voltage identification always driven low
// - Address hold floats address bits, cache outputs
// - Bus hold floats listed bus outputs
// - Stop drives strobes inactive, acknowledge follows hold
// - Stop keeps pre-stop level, never floats
// - Snoop in stop may assert cache outputs
module bus_pin_config (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic writeback_select,
  input wire logic core_ratio_strap,
  input wire logic fill_active,
  input wire logic burst_ready,
  input wire logic nonburst_ready,
  input wire logic addr_hold,
  input wire logic bus_hold,
  input wire logic hold_request,
  input wire logic stop_grant,
  input wire logic [14:0] core_pins,
  input wire logic core_cache_n,
  input wire logic core_modified_snoop_hit_n,
  input wire logic snoop_hit,
  input wire logic snoop_modified,
  input wire logic core_hold_ack,
  output logic [14:0] pin_out,
  output logic [14:0] pin_oe_n,
  output logic line_alloc_n,
  output logic line_alloc_oe_n,
  output logic modified_snoop_hit,
  output logic modified_snoop_hit_oe_n,
  output logic hold_acknowledge,
  output logic voltage_identification_out,
  output logic writeback_mode,
  output logic core_ratio_triple,
  output logic line_is_writeback,
  output logic line_mark_valid
);

  // Registered state and its next value.
  pin_state_pkg::state_t state_reg;
  pin_state_pkg::state_t state_next;

  // Synchronised reset, released two edges after reset_n rises.
  logic rst_n;
  assign rst_n = state_reg.rst_sync[1];

  // Pins floated in bus hold; address bits also float in address hold.
  localparam logic [14:0] BUS_HOLD_FLOAT = `BUS_HOLD_FLOAT_MASK;
  localparam logic [14:0] ADDR_HOLD_FLOAT = `ADDR_HOLD_FLOAT_MASK;
  // Pins forced inactive high in stop: bus lock (bit 9), multi_cycle_atomic_out
  // (bit 10) and address_strobe (bit 11). Every other pin keeps its captured level.
  localparam logic [14:0] STOP_HIGH = `STOP_HIGH_MASK;

  // Reset image of the whole state. While reset holds every bus output is driven
  // at its idle level instead of floated, so the board never sees a stray strobe.
  localparam pin_state_pkg::state_t RESET_STATE = '{
    rst_sync: 2'h0,
    wb_enable: `STRAP_RESET,
    ratio_triple: `STRAP_RESET,
    strap_done: 1'h0,
    fill_seen: 1'h0,
    line_is_wb: 1'h0,
    line_mark_valid: 1'h0,
    pwr: pin_state_pkg::PWR_RUN,
    held: `PINS_RESET,
    pins: `PINS_RESET,
    oe_n: 15'h0000,
    hold_ack: 1'h0,
    cache_pins: `CACHE_PINS_IDLE,
    cache_oe: 2'h0,
    volt_id: `VOLT_ID_LEVEL
  };

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    state_next = state_reg;
    // The synchroniser shifts ones in once the raw reset has gone away.
    state_next.rst_sync = {state_reg.rst_sync[0], 1'h1};
    state_next.line_mark_valid = 1'h0;
    // Straps are frozen once the internal reset has released; the end of this
    // process shows how they are sampled while it is still held.
    state_next.strap_done = 1'h1;
    // The identification level sits in a flip-flop so the output stays registered.
    state_next.volt_id = `VOLT_ID_LEVEL;
    // First ready of a fill marks the line; later readies are ignored.
    if (!fill_active) begin
      state_next.fill_seen = 1'h0;
    end else if ((burst_ready || nonburst_ready) && !state_reg.fill_seen) begin
      state_next.fill_seen = 1'h1;
      state_next.line_is_wb = state_reg.wb_enable & writeback_select;
      state_next.line_mark_valid = 1'h1;
    end
    // Power state tracking for the run and stop grant states.
    case (state_reg.pwr)
      pin_state_pkg::PWR_RUN: begin
        if (stop_grant) begin
          state_next.pwr = pin_state_pkg::PWR_STOP;
          state_next.held = state_reg.pins;
        end
      end
      default: begin
        if (!stop_grant) begin
          state_next.pwr = pin_state_pkg::PWR_RUN;
        end
      end
    endcase
    // Pin values: stop holds the captured level, strobes forced high.
    if (state_next.pwr == pin_state_pkg::PWR_STOP) begin
      state_next.pins = state_next.held | STOP_HIGH;
      state_next.oe_n = 15'h0000;
      state_next.hold_ack = hold_request;
      // A snoop may still pull the cache outputs active.
      state_next.cache_pins = {~(snoop_hit & snoop_modified), ~snoop_hit};
      state_next.cache_oe = 2'h0;
    end else begin
      state_next.pins = core_pins;
      state_next.hold_ack = core_hold_ack;
      state_next.cache_pins = {core_modified_snoop_hit_n, core_cache_n};
      if (bus_hold) begin
        state_next.oe_n = BUS_HOLD_FLOAT;
        state_next.cache_oe = 2'h3;
      end else if (addr_hold) begin
        state_next.oe_n = ADDR_HOLD_FLOAT;
        state_next.cache_oe = 2'h3;
      end else begin
        state_next.oe_n = 15'h0000;
        state_next.cache_oe = 2'h0;
      end
    end
    // While the released reset is still low everything sits at its reset value, except
    // the synchroniser, which keeps shifting, and the straps, which follow their pins. The last sample is therefore
    // taken on the edge that releases the internal reset, two clocks after the
    // raw reset rises, which is still inside the window the system holds them.
    if (!rst_n) begin
      state_next = RESET_STATE;
      state_next.rst_sync = {state_reg.rst_sync[0], 1'h1};
      state_next.wb_enable = writeback_select;
      state_next.ratio_triple = core_ratio_strap ? `RATIO_TRIPLE : `RATIO_DOUBLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One register holds the whole state. The asynchronous branch only loads the
  // constant reset image, whose synchroniser bits restart at zero; everything
  // else waits for the released copy through the next-state logic above.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops.
  assign pin_out = state_reg.pins;
  assign pin_oe_n = state_reg.oe_n;
  assign line_alloc_n = state_reg.cache_pins[0];
  assign modified_snoop_hit = state_reg.cache_pins[1];
  assign line_alloc_oe_n = state_reg.cache_oe[0];
  assign modified_snoop_hit_oe_n = state_reg.cache_oe[1];
  assign hold_acknowledge = state_reg.hold_ack;
  // The low-voltage identification is driven low from its flip-flop.
  assign voltage_identification_out = state_reg.volt_id;
  assign writeback_mode = state_reg.wb_enable;
  assign core_ratio_triple = state_reg.ratio_triple;
  assign line_is_writeback = state_reg.line_is_wb;
  assign line_mark_valid = state_reg.line_mark_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_mode_freezes: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(state_reg.strap_done) |-> $stable(writeback_mode) && $stable(core_ratio_triple))
    else $error("strap latch changed after reset release");
  chk_wt_without_wb: assert property (@(posedge core_clk) disable iff (!rst_n)
    line_mark_valid && !writeback_mode |-> !line_is_writeback)
    else $error("line marked write-back without write-back mode");
  chk_fill_sample: assert property (@(posedge core_clk) disable iff (!rst_n)
    fill_active && (burst_ready || nonburst_ready) && !state_reg.fill_seen
    |=> line_mark_valid && line_is_writeback == (writeback_mode && $past(writeback_select)))
    else $error("line fill sample wrong");
  chk_voltage_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    voltage_identification_out == 1'h0)
    else $error("voltage identification not low");
  chk_addr_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !stop_grant && addr_hold && !bus_hold |=> pin_oe_n == ADDR_HOLD_FLOAT && line_alloc_oe_n)
    else $error("address hold float set wrong");
  chk_bus_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !stop_grant && bus_hold |=> pin_oe_n == BUS_HOLD_FLOAT && modified_snoop_hit_oe_n)
    else $error("bus hold float set wrong");
  chk_stop_strobes: assert property (@(posedge core_clk) disable iff (!rst_n)
    stop_grant |=> (pin_out & STOP_HIGH) == STOP_HIGH && hold_acknowledge == $past(hold_request))
    else $error("stop state strobes or acknowledge wrong");
  chk_stop_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    stop_grant ##1 stop_grant |=> pin_oe_n == 15'h0000 && $stable(pin_out))
    else $error("stop state pin level moved or floated");
  // Outside hold and stop every listed output is driven with the core's value.
  chk_run_drives: assert property (@(posedge core_clk) disable iff (!rst_n)
    !stop_grant && !bus_hold && !addr_hold |=> pin_oe_n == 15'h0000 && pin_out == $past(core_pins))
    else $error("run state pins not driven from core");
  chk_snoop_in_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    stop_grant |=> line_alloc_n == !$past(snoop_hit)
      && modified_snoop_hit == !($past(snoop_hit) && $past(snoop_modified)))
    else $error("snoop result in stop wrong");
  chk_hold_ack_run: assert property (@(posedge core_clk) disable iff (!rst_n)
    !stop_grant |=> hold_acknowledge == $past(core_hold_ack))
    else $error("hold acknowledge not driven in run");
endmodule : bus_pin_config

/* bus_pin_config_tb.sv */
// Self-checking testbench for the strap and pin state block.
`timescale 1ns/10ps
module bus_pin_config_tb;
  logic core_clk = 1'h0, reset_n = 1'h0, strap_wb = 1'h0, core_ratio_strap = 1'h0;
  logic go = 1'h0, go_wb = 1'h0, go_burst = 1'h0, fill_active, burst_ready;
  logic [1:0] go_wait = 2'h0;
  logic nonburst_ready, writeback_select, busy, line_alloc_n, line_alloc_oe_n;
  logic addr_hold = 1'h0, bus_hold = 1'h0, hold_request = 1'h0, stop_grant = 1'h0;
  logic core_cache_n = 1'h1, core_modified_snoop_hit_n = 1'h1, snoop_hit = 1'h0, snoop_modified = 1'h0;
  logic core_hold_ack = 1'h0, modified_snoop_hit, modified_snoop_hit_oe_n, hold_acknowledge;
  logic voltage_identification_out, writeback_mode, core_ratio_triple;
  logic line_is_writeback, line_mark_valid;
  logic [14:0] core_pins = 15'h0000, pin_out, pin_oe_n, v;
  logic exp_q[$]; // Expected line types, oldest first.
  int errors = 0, compares = 0, cycles = 0;
  bus_pin_config bus_pin_config_i (
    .core_clk(core_clk), .reset_n(reset_n), .writeback_select(writeback_select),
    .core_ratio_strap(core_ratio_strap), .fill_active(fill_active),
    .burst_ready(burst_ready), .nonburst_ready(nonburst_ready), .addr_hold(addr_hold),
    .bus_hold(bus_hold), .hold_request(hold_request), .stop_grant(stop_grant),
    .core_pins(core_pins), .core_cache_n(core_cache_n), .core_modified_snoop_hit_n(core_modified_snoop_hit_n),
    .snoop_hit(snoop_hit), .snoop_modified(snoop_modified), .core_hold_ack(core_hold_ack),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .line_alloc_n(line_alloc_n),
    .line_alloc_oe_n(line_alloc_oe_n), .modified_snoop_hit(modified_snoop_hit),
    .modified_snoop_hit_oe_n(modified_snoop_hit_oe_n), .hold_acknowledge(hold_acknowledge),
    .voltage_identification_out(voltage_identification_out),
    .writeback_mode(writeback_mode), .core_ratio_triple(core_ratio_triple),
    .line_is_writeback(line_is_writeback), .line_mark_valid(line_mark_valid)
  );
  fill_partner fill_partner_i (
    .core_clk(core_clk), .strap_wb(strap_wb), .go(go), .go_wb(go_wb), .go_burst(go_burst),
    .go_wait(go_wait), .fill_active(fill_active), .burst_ready(burst_ready),
    .nonburst_ready(nonburst_ready), .writeback_select(writeback_select), .busy(busy)
  );
  always #2 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  // Compares one result; narrower values are zero extended.
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step
  // Prints the verdict and ends the run.
  task automatic results;
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // Runs one fill through the partner; the bound stops a stuck handshake.
  task automatic fill(input logic wb, input logic br);
    int n;
    n = 0;
    go_wb = wb;
    go_burst = br;
    go_wait = 2'($urandom_range(0, 3));
    go = 1'h1;
    exp_q.push_back(strap_wb & wb);
    while (busy !== 1'h1 && n < 20) begin
      step;
      n++;
    end
    go = 1'h0;
    while (busy === 1'h1 && n < 40) begin
      step;
      n++;
    end
    step;
    chk(15'(exp_q.size()), 15'h0000);
  endtask : fill
  //////////////////////////////////////////////////////////////////////////////
  // Watches marks at the falling edge, where registered outputs have settled.
  always @(negedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      results;
    end
    if (line_mark_valid === 1'h1) begin
      if (exp_q.size() == 0) chk(15'h0001, 15'h0000);
      else chk(15'(line_is_writeback), 15'(exp_q.pop_front()));
    end
  end
  // Main sequence: every strap pairing, fills, then hold and stop pin states.
  initial begin
    void'($urandom(32'h5A7BD160));
    for (int m = 0; m < 4; m++) begin
      #1;
      reset_n = 1'h0;
      strap_wb = m[0];
      core_ratio_strap = m[1];
      repeat (8) step;
      reset_n = 1'h1;
      repeat (5) step;
      core_ratio_strap = !m[1];
      chk(15'(writeback_mode), 15'(m[0]));
      for (int f = 0; f < 4; f++) fill(f[0], f[1]);
      chk(15'(core_ratio_triple), 15'(m[1]));
    end
    for (int t = 0; t < 3; t++) begin
      v = 15'($urandom);
      core_pins = v;
      step;
      addr_hold = 1'h1;
      step;
      chk(pin_oe_n, 15'h6000);
      chk(15'({line_alloc_oe_n, modified_snoop_hit_oe_n}), 15'h0003);
      chk(pin_out, v);
      chk(15'({line_alloc_n, modified_snoop_hit}), 15'h0003);
      addr_hold = 1'h0;
      bus_hold = 1'h1;
      core_hold_ack = 1'h1;
      step;
      chk(pin_oe_n, 15'h7FFF);
      chk(15'(hold_acknowledge), 15'h0001);
      chk(15'({line_alloc_oe_n, modified_snoop_hit_oe_n}), 15'h0003);
      chk(15'(voltage_identification_out), 15'h0000);
      bus_hold = 1'h0;
      core_hold_ack = 1'h0;
      step;
      stop_grant = 1'h1;
      hold_request = 1'h1;
      {core_cache_n, core_modified_snoop_hit_n} = 2'h0;
      core_pins = ~v;
      step;
      chk(pin_out, v | 15'h0E00);
      chk(pin_oe_n, 15'h0000);
      chk(15'({line_alloc_n, modified_snoop_hit, hold_acknowledge}), 15'h0007);
      hold_request = 1'h0;
      {snoop_hit, snoop_modified} = 2'h3;
      step;
      chk(15'({line_alloc_n, modified_snoop_hit, hold_acknowledge}), 15'h0000);
      chk(15'(voltage_identification_out), 15'h0000);
      {stop_grant, snoop_hit, snoop_modified, core_cache_n, core_modified_snoop_hit_n} = 5'h03;
    end
    results;
  end
endmodule : bus_pin_config_tb

/* fill_partner.sv */
// Bus-side partner model that holds the strap and runs line fills.
`timescale 1ns/10ps
module fill_partner (
  input wire logic core_clk,
  input wire logic strap_wb,
  input wire logic go,
  input wire logic go_wb,
  input wire logic go_burst,
  input wire logic [1:0] go_wait,
  output logic fill_active,
  output logic burst_ready,
  output logic nonburst_ready,
  output logic writeback_select,
  output logic busy
);
  logic in_fill; // High while a fill owns the line type level.
  logic fill_ws; // Line type level shown during a fill.
  // Outside fills the strap stands, so it is valid across every reset edge.
  assign writeback_select = in_fill ? fill_ws : strap_wb;
  //////////////////////////////////////////////////////////////////////////////
  // Each fill: wait states, then four readies; only the first carries the type.
  initial begin
    {in_fill, fill_ws, fill_active, burst_ready, nonburst_ready, busy} = 6'h00;
    forever begin
      @(posedge core_clk);
      if (go === 1'h1) begin
        #1;
        busy = 1'h1;
        in_fill = 1'h1;
        fill_ws = !go_wb;
        fill_active = 1'h1;
        repeat (go_wait) begin
          @(posedge core_clk);
          #1;
        end
        for (int k = 0; k < 4; k++) begin
          // Later beats carry the inverse, so a late sample shows up.
          fill_ws = (k == 0) ? go_wb : !go_wb;
          burst_ready = go_burst;
          nonburst_ready = !go_burst;
          @(posedge core_clk);
          #1;
        end
        {in_fill, fill_active, burst_ready, nonburst_ready, busy} = 5'h00;
      end
    end
  end
endmodule : fill_partner

/* pin_state_map.svh */
// Constant map for the bus configuration and pin state block.
`ifndef PIN_STATE_MAP_SVH
`define PIN_STATE_MAP_SVH
// Ratio codes reported on core_ratio_triple.
`define RATIO_DOUBLE 1'h0
`define RATIO_TRIPLE 1'h1
// Reset value of the latched strap bits.
`define STRAP_RESET 1'h0
// Idle (inactive) level of an active-low output.
`define INACTIVE_HIGH 1'h1
// Voltage identification level, always low.
`define VOLT_ID_LEVEL 1'h0
// Level of the fifteen bus pins while reset holds: every active-low strobe idle.
`define PINS_RESET 15'h7FFF
// Pins floated in bus hold: the whole fifteen-pin vector.
`define BUS_HOLD_FLOAT_MASK 15'h7FFF
// Pins floated in address hold: low_address_bits at bits 13 and 14.
`define ADDR_HOLD_FLOAT_MASK 15'h6000
// Pins forced high in stop: bus lock (9), multi_cycle_atomic_out (10), address_strobe (11).
`define STOP_HIGH_MASK 15'h0E00
// Idle level of the modified_snoop_hit and line-allocatable pair.
`define CACHE_PINS_IDLE 2'h3
`endif

/* pin_state_pkg.sv */
// Types for the bus configuration and pin state block.
package pin_state_pkg;
  // Power state of the bus interface.
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_STOP
  } pwr_state_t;
  // Whole registered state of the block.
  typedef struct packed {
    logic [1:0] rst_sync;
    logic wb_enable;
    logic ratio_triple;
    logic strap_done;
    logic fill_seen;
    logic line_is_wb;
    logic line_mark_valid;
    pwr_state_t pwr;
    logic [14:0] held;
    logic [14:0] pins;
    logic [14:0] oe_n;
    logic hold_ack;
    logic [1:0] cache_pins; // Modified-hit level (bit 1) and line-allocatable level (bit 0).
    logic [1:0] cache_oe; // Their output enables; high floats the pin.
    logic volt_id; // Registered voltage identification level.
  } state_t;
endpackage : pin_state_pkg
